/* File: rtl/obsl_defs.vh */
// Constants for the option bit shadow loader
`ifndef OBSL_DEFS_VH
`define OBSL_DEFS_VH
`define OBSL_ADDR_OPTION_BYTE_ZERO 8'hFE
`define OBSL_ADDR_OPTION_BYTE_ONE 8'hFF
`define OBSL_REG_OPTION_BYTE_ZERO_SHADOW 12'hD0E
`define OBSL_REG_OPTION_BYTE_ONE_SHADOW 12'hD0F
`define OBSL_REG_PROTECT 12'hD0D
`define OBSL_PRESET 8'hFF
`define OBSL_SMR_FULL_RESET_BIT 5
`define OBSL_SMR_CLKDIV_BIT 0
`define OBSL_BIT_WDT 7
`define OBSL_BIT_WIDE_STACK 3
`define OBSL_BIT_CLK_HALVE 2
`define OBSL_BIT_LOWER_PROT 1
`define OBSL_BIT_ACCESS_PROT 0
`define OBSL_FLASH_LATENCY 2'h2
`endif

/* File: rtl/obsl_flash_fetch.v */
// Fetches one information block byte with a fixed read latency
`timescale 1ns/100ps
`include "obsl_defs.vh"
module obsl_flash_fetch (
  input wire clk,
  input wire rstN,
  input wire start,
  input wire [7:0] addr,
  output reg [7:0] infoAddr,
  output reg infoRead,
  input wire [7:0] infoData,
  output reg done,
  output reg [7:0] data
);
  reg [1:0] wait_cnt;
  reg busy;
  always @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      infoAddr <= 8'h00;
      infoRead <= 1'b0;
      done <= 1'b0;
      data <= 8'h00;
      wait_cnt <= 2'h0;
      busy <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start && !busy)
      begin
        infoAddr <= addr;
        infoRead <= 1'b1;
        busy <= 1'b1;
        wait_cnt <= `OBSL_FLASH_LATENCY;
      end
      else if (busy)
      begin
        if (wait_cnt == 2'h0)
        begin
          data <= infoData;
          done <= 1'b1;
          busy <= 1'b0;
          infoRead <= 1'b0;
        end
        else
          wait_cnt <= wait_cnt - 2'h1;
      end
    end
  end
endmodule

/* File: rtl/obsl_loader.v */
// Option byte shadow loader: reset-time load, CPU access, protection latches
// Contract
// - On power-on, or recovery reset with control bit 5 set, load option bytes.
// - New flash option values take effect only after the next reload.
// - Feature enables other than the protection flops come from shadow registers, never straight from flash.
// - Option byte 0 is read from FEh, option byte 1 from FFh.
// - CPU reads and writes all shadow bits except option byte 1 bits 1:0.
// - Byte 0 outputs hold the preset until byte 0 is fetched, byte 1 outputs until the load has finished.
// - Shadows are preset to a fixed value at reset start.
// - Option byte 0 bit 7: 1 watchdog by instruction, 0 always on.
// - Option byte 0 bits 6:0 are active-low pull-up enables per port.
// - Option byte 0 shadow is an 8-bit register at D0Eh.
// - Power-on reset samples option byte 1 bits 1:0 into protection flops.
// - Protection flop values are readable at their own register address.
// - Software writes never change the protection flops.
// - Option byte 1: 7:4 reserved, 3 stack, 2 divider, 1:0 protect.
// - Bit 3 one gives 16-bit stack, zero gives 8-bit stack.
// - With control bit 0 low, bit 2 one halves the crystal clock.
`timescale 1ns/100ps
`include "obsl_defs.vh"
module obsl_loader (
  input wire sys_clk,
  input wire arst_n,
  input wire porReset,
  input wire recoveryReset,
  input wire resetEnding,
  input wire [7:0] recovery_control_register,
  output wire [7:0] infoAddr,
  output wire infoRead,
  input wire [7:0] infoData,
  input wire [11:0] regAddr,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regWdata,
  output reg [7:0] regRdata,
  output reg loadDone,
  output reg watchdog_policy,
  output reg port4_pullup_n,
  output reg port3_pullup_n,
  output reg port2_pullup_n,
  output reg port1_high_pullup_n,
  output reg port1_low_pullup_n,
  output reg port0_high_pullup_n,
  output reg port0_low_pullup_n,
  output reg wide_stack_select,
  output reg clock_halving_enable,
  output reg lower_half_protect,
  output reg flash_access_protect
);
  localparam S_IDLE = 2'h0;
  localparam S_OPTION_BYTE_ZERO = 2'h1;
  localparam S_OPTION_BYTE_ONE = 2'h2;
  reg rstMeta;
  reg rstSync;
  reg [1:0] state;
  reg [1:0] next_state;
  reg [7:0] option_byte0_shadow;
  reg [7:0] option_byte1_shadow;
  reg loadIsPor;
  reg fetchStart;
  reg [7:0] fetchAddr;
  wire fetchDone;
  wire [7:0] fetchData;
  wire loadRequest;
  wire hitOpt0;
  wire hitOpt1;

  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end
    else
    begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // Load only in the tail of reset so flash supply has settled
  assign loadRequest = resetEnding && (porReset ||
    (recoveryReset && recovery_control_register[`OBSL_SMR_FULL_RESET_BIT]));

  obsl_flash_fetch u_fetch (
    .clk(sys_clk),
    .rstN(rstSync),
    .start(fetchStart),
    .addr(fetchAddr),
    .infoAddr(infoAddr),
    .infoRead(infoRead),
    .infoData(infoData),
    .done(fetchDone),
    .data(fetchData)
  );

  always @*
  begin
    next_state = state;
    fetchStart = 1'b0;
    fetchAddr = `OBSL_ADDR_OPTION_BYTE_ZERO;
    case (state)
      S_IDLE:
      begin
        if (loadRequest)
        begin
          next_state = S_OPTION_BYTE_ZERO;
        end
      end
      S_OPTION_BYTE_ZERO:
      begin
        // Holding start through the done cycle would refetch byte 0 into byte 1
        fetchStart = !fetchDone;
        fetchAddr = `OBSL_ADDR_OPTION_BYTE_ZERO;
        if (fetchDone)
          next_state = S_OPTION_BYTE_ONE;
      end
      S_OPTION_BYTE_ONE:
      begin
        fetchStart = !fetchDone;
        fetchAddr = `OBSL_ADDR_OPTION_BYTE_ONE;
        if (fetchDone)
          next_state = S_IDLE;
      end
      default:
        next_state = S_IDLE;
    endcase
  end

  assign hitOpt0 = (regAddr == `OBSL_REG_OPTION_BYTE_ZERO_SHADOW);
  assign hitOpt1 = (regAddr == `OBSL_REG_OPTION_BYTE_ONE_SHADOW);

  // Preset on reset start gives defined erased values before load
  always @(posedge sys_clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      state <= S_IDLE;
      option_byte0_shadow <= `OBSL_PRESET;
      option_byte1_shadow <= `OBSL_PRESET;
      loadIsPor <= 1'b0;
      loadDone <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (state == S_IDLE && loadRequest)
      begin
        loadIsPor <= porReset;
        loadDone <= 1'b0;
      end
      if (state == S_OPTION_BYTE_ZERO && fetchDone)
        option_byte0_shadow <= fetchData;
      else if (regWrite && hitOpt0)
        option_byte0_shadow <= regWdata;
      if (state == S_OPTION_BYTE_ONE && fetchDone)
      begin
        option_byte1_shadow <= fetchData;
        loadDone <= 1'b1;
      end
      else if (regWrite && hitOpt1)
        option_byte1_shadow[7:2] <= regWdata[7:2];
    end
  end

  // Protection flops: only the power-on load touches them, no bus path
  always @(posedge sys_clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      lower_half_protect <= 1'b1;
      flash_access_protect <= 1'b1;
    end
    else if (state == S_OPTION_BYTE_ONE && fetchDone && loadIsPor)
    begin
      lower_half_protect <= fetchData[`OBSL_BIT_LOWER_PROT];
      flash_access_protect <= fetchData[`OBSL_BIT_ACCESS_PROT];
    end
  end

  // Feature outputs follow the shadows one clock later
  always @(posedge sys_clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      watchdog_policy <= 1'b1;
      port4_pullup_n <= 1'b1;
      port3_pullup_n <= 1'b1;
      port2_pullup_n <= 1'b1;
      port1_high_pullup_n <= 1'b1;
      port1_low_pullup_n <= 1'b1;
      port0_high_pullup_n <= 1'b1;
      port0_low_pullup_n <= 1'b1;
      wide_stack_select <= 1'b1;
      clock_halving_enable <= 1'b1;
    end
    else
    begin
      watchdog_policy <= option_byte0_shadow[`OBSL_BIT_WDT];
      port4_pullup_n <= option_byte0_shadow[6];
      port3_pullup_n <= option_byte0_shadow[5];
      port2_pullup_n <= option_byte0_shadow[4];
      port1_high_pullup_n <= option_byte0_shadow[3];
      port1_low_pullup_n <= option_byte0_shadow[2];
      port0_high_pullup_n <= option_byte0_shadow[1];
      port0_low_pullup_n <= option_byte0_shadow[0];
      wide_stack_select <= option_byte1_shadow[`OBSL_BIT_WIDE_STACK];
      // Divider only honours this when the recovery control bit 0 is low
      clock_halving_enable <= option_byte1_shadow[`OBSL_BIT_CLK_HALVE] &
        ~recovery_control_register[`OBSL_SMR_CLKDIV_BIT];
    end
  end

  always @(posedge sys_clk or negedge rstSync)
  begin
    if (!rstSync)
      regRdata <= 8'h00;
    else if (regRead)
    begin
      if (hitOpt0)
        regRdata <= option_byte0_shadow;
      else if (hitOpt1)
        regRdata <= {option_byte1_shadow[7:2], lower_half_protect, flash_access_protect};
      else if (regAddr == `OBSL_REG_PROTECT)
        regRdata <= {6'h00, lower_half_protect, flash_access_protect};
      else
        regRdata <= 8'h00;
    end
  end
endmodule

/* File: sim/obsl_flash_model.sv */
// Flash information block model holding the two option bytes
`timescale 1ns/100ps
module obsl_flash_model (
  input wire clk,
  input wire [7:0] infoAddr,
  input wire infoRead,
  output reg [7:0] infoData,
  input wire [7:0] option_byte_zero,
  input wire [7:0] option_byte_one
);
  reg [2:0] hold = 3'h0;
  initial infoData = 8'h00;
  // Released bus drifts, so a late sample cannot match by luck
  always @(posedge clk)
    if (infoRead)
    begin
      hold <= 3'h4;
      infoData <= infoAddr == 8'hFE ? option_byte_zero : infoAddr == 8'hFF ? option_byte_one : ~infoAddr;
    end
    else if (hold != 3'h0)
      hold <= hold - 3'h1;
    else
      infoData <= ~infoData;
endmodule

/* File: sim/obsl_checker_asserts.sv */
// Port checker for the option bit shadow loader
`timescale 1ns/100ps
module obsl_checker (
  input wire sys_clk,
  input wire arst_n,
  input wire porReset,
  input wire recoveryReset,
  input wire resetEnding,
  input wire [7:0] recovery_control_register,
  input wire [7:0] infoAddr,
  input wire infoRead,
  input wire [11:0] regAddr,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regWdata,
  input wire [7:0] regRdata,
  input wire loadDone,
  input wire watchdog_policy,
  input wire port4_pullup_n,
  input wire port3_pullup_n,
  input wire port2_pullup_n,
  input wire port1_high_pullup_n,
  input wire port1_low_pullup_n,
  input wire port0_high_pullup_n,
  input wire port0_low_pullup_n,
  input wire lower_half_protect,
  input wire flash_access_protect
);
  wire [7:0] b0 = {watchdog_policy, port4_pullup_n, port3_pullup_n, port2_pullup_n,
    port1_high_pullup_n, port1_low_pullup_n, port0_high_pullup_n, port0_low_pullup_n};
  wire [1:0] prot = {lower_half_protect, flash_access_protect};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence s_fe; infoRead && infoAddr == 8'hFE; endsequence
  sequence s_ff; infoRead && infoAddr == 8'hFF; endsequence
  property p_fetch; $rose(infoRead) |-> infoAddr == 8'hFE || infoAddr == 8'hFF; endproperty
  a_fetch: assert property (p_fetch) else $error("bad fetch address");
  property p_order; $rose(resetEnding) && (porReset || recoveryReset &&
    recovery_control_register[5]) |-> ##[1:6] s_fe ##[1:8] s_ff ##[1:8] loadDone; endproperty
  a_order: assert property (p_order) else $error("load sequence wrong");
  property p_noLoad; $rose(resetEnding) && !porReset && !recovery_control_register[5]
    |=> !infoRead [*8]; endproperty
  a_noLoad: assert property (p_noLoad) else $error("unwanted load");
  property p_write; regWrite && regAddr == 12'hD0E && loadDone
    |-> ##2 b0 == $past(regWdata, 2); endproperty
  a_write: assert property (p_write) else $error("write not on outputs");
  property p_read; regRead && regAddr == 12'hD0E |=> regRdata == b0; endproperty
  a_read: assert property (p_read) else $error("read data wrong");
  property p_protRd; regRead && regAddr == 12'hD0D |=> regRdata[1:0] == prot; endproperty
  a_protRd: assert property (p_protRd) else $error("protect read wrong");
  property p_protHold; !porReset |=> $stable(prot); endproperty
  a_protHold: assert property (p_protHold) else $error("protect changed");
  property p_preset; $rose(arst_n) |-> b0 == 8'hFF && prot == 2'h3 && !loadDone; endproperty
  a_preset: assert property (p_preset) else $error("no preset");
endmodule
bind obsl_loader obsl_checker obsl_checker_inst (.*);

/* File: sim/obsl_loader_bench.sv */
// Self-checking bench for the option bit shadow loader
`timescale 1ns/100ps
module obsl_loader_bench;
  reg sys_clk, arst_n, porReset, recoveryReset, resetEnding, regWrite, regRead;
  reg [7:0] recovery_control_register, regWdata, option_byte_zero, option_byte_one;
  reg [11:0] regAddr;
  wire [7:0] infoAddr, infoData, regRdata;
  wire infoRead, loadDone, watchdog_policy, port4_pullup_n, port3_pullup_n, port2_pullup_n;
  wire port1_high_pullup_n, port1_low_pullup_n, port0_high_pullup_n, port0_low_pullup_n;
  wire wide_stack_select, clock_halving_enable, lower_half_protect, flash_access_protect;
  wire [7:0] b0 = {watchdog_policy, port4_pullup_n, port3_pullup_n, port2_pullup_n,
    port1_high_pullup_n, port1_low_pullup_n, port0_high_pullup_n, port0_low_pullup_n};
  integer errors = 0;
  integer num_checks = 0;
  integer cycles = 0;
  obsl_loader obsl_loader_inst (.*);
  obsl_flash_model obsl_flash_model_inst (.clk(sys_clk), .infoAddr(infoAddr),
    .infoRead(infoRead), .infoData(infoData), .option_byte_zero(option_byte_zero), .option_byte_one(option_byte_one));
  task chk(input [63:0] what, input [7:0] exp, input [7:0] got);
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("MISMATCH %0s expected %h seen %h", what, exp, got);
    end
  endtask
  task wr(input [11:0] a, input [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'h1;
    @(posedge sys_clk);
    regWrite <= 1'h0;
  endtask
  task rd(input [11:0] a, input [7:0] m, input [7:0] e);
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1'h1;
    @(posedge sys_clk);
    regRead <= 1'h0;
    #1 chk("rdata", e, regRdata & m);
  endtask
  task load(input p, input r, input [7:0] c);
    @(posedge sys_clk);
    porReset <= p;
    recoveryReset <= r;
    recovery_control_register <= c;
    resetEnding <= 1'h1;
    repeat (20) @(posedge sys_clk);
    porReset <= 1'h0;
    recoveryReset <= 1'h0;
    resetEnding <= 1'h0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    sys_clk = 1'h0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      errors = errors + 1;
      tally_and_finish;
    end
  end
  initial
  begin
    arst_n = 1'h0;
    porReset = 1'h1;
    {recoveryReset, resetEnding, regWrite, regRead} = 4'h0;
    {recovery_control_register, regWdata, regAddr} = 28'h0;
    option_byte_zero = 8'hA5;
    option_byte_one = 8'hF6;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'h1;
    repeat (3) @(posedge sys_clk);
    load(1'h1, 1'h0, 8'h00);
    chk("done", 8'h01, {7'h0, loadDone});
    chk("opt1out", 8'h01, {6'h0, wide_stack_select, clock_halving_enable});
    rd(12'hD0E, 8'hFF, 8'hA5);
    chk("out", 8'hA5, b0);
    rd(12'hD0F, 8'hFF, 8'hF6);
    rd(12'hD0D, 8'h03, 8'h02);
    wr(12'hD0E, 8'h3C);
    rd(12'hD0E, 8'hFF, 8'h3C);
    chk("out", 8'h3C, b0);
    wr(12'hD0F, 8'hF9);
    rd(12'hD0F, 8'hFF, 8'hFA);
    chk("opt1out", 8'h02, {6'h0, wide_stack_select, clock_halving_enable});
    wr(12'hD0D, 8'h01);
    rd(12'hD0D, 8'h03, 8'h02);
    option_byte_zero <= 8'h0F;
    option_byte_one <= 8'hF5;
    repeat (4) @(posedge sys_clk);
    #1;
    chk("out", 8'h3C, b0);
    load(1'h0, 1'h1, 8'h00);
    chk("out", 8'h3C, b0);
    load(1'h0, 1'h1, 8'h20);
    chk("out", 8'h0F, b0);
    rd(12'hD0D, 8'h03, 8'h02);
    chk("opt1out", 8'h01, {6'h0, wide_stack_select, clock_halving_enable});
    @(posedge sys_clk);
    recovery_control_register <= 8'h21;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("opt1out", 8'h00, {6'h0, wide_stack_select, clock_halving_enable});
    tally_and_finish;
  end
endmodule
